// ---- src/apm_top.sv ----
// What this block does
// RULE1 - A mode byte with select 110 enters partial power-down.
// RULE2 - In partial power-down the reference and bias stay powered, other analog is off.
// RULE3 - Partial power-down is left only by a full valid mode byte of another mode, never by chip select alone.
// RULE4 - A mode byte with select 111 enters full power-down with all analog off.
// RULE5 - Full power-down is left only by a full valid mode byte of another mode, never by a chip-select glitch.
// RULE6 - With the internal reference the host waits 10 ms after leaving full power-down before converting.
// RULE7 - At power-on the device is fully powered in external clock mode.
// RULE8 - At power-on every channel is single-ended bipolar plus or minus three times reference.
// RULE9 - After power-up the host waits for supplies and 10 ms reference settling before converting.
// RULE10 - Range code 110 selects single-ended unipolar zero to three times reference.
// RULE11 - Range code 011 selects single-ended unipolar zero to one and a half times reference.
// RULE12 - The mode byte starts at the first 1 after chip select falls, select in bits 6..4, tail 1000.
// RULE13 - Select codes decode to the six modes, 011 and 101 being reserved.
// RULE14 - Select 100 restores full power, external clock mode and default channel ranges.
// RULE15 - A reserved select code leaves the mode and power state unchanged.
// RULE16 - The serial receiver keeps working in both power-down states.
module apm_top #(
   parameter int NUM_CH = 8
) (
   input  wire logic                  core_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  sclk_in,
   input  wire logic                  cs_n_in,
   input  wire logic                  din_in,
   input  wire logic                  cfg_we_in,
   input  wire logic [$clog2(NUM_CH)-1:0] cfg_ch_in,
   input  wire logic                  cfg_diff_in,
   input  wire logic [2:0]            cfg_range_in,
   output logic [2:0]                 conv_mode_out,
   output logic                       part_pd_out,
   output logic                       full_pd_out,
   output logic                       ref_bias_on_out,
   output logic                       analog_on_out,
   output logic [NUM_CH-1:0]          ch_diff_out,
   output logic [NUM_CH*3-1:0]        ch_range_out,
   output logic [NUM_CH-1:0]          ch_unipolar_out,
   output logic [NUM_CH*2-1:0]        ch_span_out
);
   localparam int CHW = $clog2(NUM_CH);
   if (NUM_CH < 2 || NUM_CH > 8) begin : g_bad_num_ch
      $error("NUM_CH must be 2..8");
   end
   ////////////////////////////////////////////////////////////////
   apm_ser_if ser ();
   apm_ser_rx u_rx (
      .core_clk_in (core_clk_in),
      .rst_in      (rst_in),
      .sclk_in     (sclk_in),
      .cs_n_in     (cs_n_in),
      .din_in      (din_in),
      .rx          (ser.rx)
   ); // RULE16
   ////////////////////////////////////////////////////////////////
   // Mode byte decode
   wire [2:0] msel      = ser.byte_val[apm_pkg::MSEL_HI:apm_pkg::MSEL_LO];
   wire       is_mode   = ser.byte_vld & ser.byte_val[apm_pkg::START_BIT]
                        & (ser.byte_val[3:0] == apm_pkg::MODE_TAIL); // RULE12
   wire       rsvd      = (msel == apm_pkg::MODE_RSVD3) | (msel == apm_pkg::MODE_RSVD5); // RULE13
   wire       act       = is_mode & ~rsvd; // RULE15
   wire       do_reset  = act & (msel == apm_pkg::MODE_RESET); // RULE14
   wire       go_part   = act & (msel == apm_pkg::MODE_PART_PD); // RULE1
   wire       go_full   = act & (msel == apm_pkg::MODE_FULL_PD); // RULE4
   wire       go_conv   = act & ~msel[2];
   apm_pkg::apm_pwr_t pwr_r;
   apm_pkg::apm_pwr_t pwr_nxt;
   logic [2:0]        conv_r;
   logic [2:0]        conv_nxt;
   // Only a decoded byte moves state; chip select edges never do
   always_comb begin
      pwr_nxt  = pwr_r;
      conv_nxt = conv_r;
      case (pwr_r)
         apm_pkg::APM_ACTIVE,
         apm_pkg::APM_PART_PD,
         apm_pkg::APM_FULL_PD: begin
            if (go_part) begin
               pwr_nxt = apm_pkg::APM_PART_PD; // RULE1 RULE5
            end else if (go_full) begin
               pwr_nxt = apm_pkg::APM_FULL_PD; // RULE4 RULE3
            end else if (do_reset) begin
               pwr_nxt  = apm_pkg::APM_ACTIVE; // RULE14
               conv_nxt = apm_pkg::MODE_EXT_CLK;
            end else if (go_conv) begin
               pwr_nxt  = apm_pkg::APM_ACTIVE; // RULE3 RULE5
               conv_nxt = msel;
            end
         end
         default: pwr_nxt = apm_pkg::PWR_RESET;
      endcase
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         pwr_r  <= apm_pkg::PWR_RESET; // RULE7
         conv_r <= apm_pkg::CONV_RESET;
      end else begin
         pwr_r  <= pwr_nxt;
         conv_r <= conv_nxt;
      end
   end
   ////////////////////////////////////////////////////////////////
   // Per-channel input configuration
   logic              diff_r [NUM_CH];
   logic [2:0]        rng_r [NUM_CH];
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         wire wr = cfg_we_in & (cfg_ch_in == CHW'(g));
         always_ff @(posedge core_clk_in or posedge rst_in) begin
            if (rst_in) begin
               diff_r[g] <= apm_pkg::DIFF_RESET; // RULE8
               rng_r[g]  <= apm_pkg::RANGE_RESET;
            end else if (do_reset) begin
               diff_r[g] <= apm_pkg::DIFF_RESET; // RULE14
               rng_r[g]  <= apm_pkg::RANGE_RESET;
            end else if (wr) begin
               diff_r[g] <= cfg_diff_in;
               rng_r[g]  <= cfg_range_in;
            end
         end
         // Span: 2 = three times ref, 1 = one and a half times, 0 = other
         wire uni3  = ~diff_r[g] & (rng_r[g] == apm_pkg::RANGE_UNI_3X); // RULE10
         wire uni15 = ~diff_r[g] & (rng_r[g] == apm_pkg::RANGE_UNI_1P5); // RULE11
         assign ch_unipolar_out[g]     = uni3 | uni15;
         assign ch_span_out[g*2 +: 2]  = uni3 ? 2'h2 : (uni15 ? 2'h1 : 2'h0);
         assign ch_range_out[g*3 +: 3] = rng_r[g];
         assign ch_diff_out[g]         = diff_r[g];
      end
   endgenerate
   ////////////////////////////////////////////////////////////////
   assign conv_mode_out   = conv_r;
   assign part_pd_out     = (pwr_r == apm_pkg::APM_PART_PD);
   assign full_pd_out     = (pwr_r == apm_pkg::APM_FULL_PD);
   assign ref_bias_on_out = (pwr_r != apm_pkg::APM_FULL_PD); // RULE2
   assign analog_on_out   = (pwr_r == apm_pkg::APM_ACTIVE); // RULE2
endmodule

// ---- src/apm_pkg.sv ----
package apm_pkg;
   // Mode-select codes
   localparam logic [2:0] MODE_EXT_CLK  = 3'h0;
   localparam logic [2:0] MODE_EXT_ACQ  = 3'h1;
   localparam logic [2:0] MODE_INT_CLK  = 3'h2;
   localparam logic [2:0] MODE_RSVD3    = 3'h3;
   localparam logic [2:0] MODE_RESET    = 3'h4;
   localparam logic [2:0] MODE_RSVD5    = 3'h5;
   localparam logic [2:0] MODE_PART_PD  = 3'h6;
   localparam logic [2:0] MODE_FULL_PD  = 3'h7;
   // Mode byte layout
   localparam int         START_BIT     = 7;
   localparam int         MSEL_HI       = 6;
   localparam int         MSEL_LO       = 4;
   localparam logic [3:0] MODE_TAIL     = 4'h8;
   localparam logic [7:0] START_MASK    = 8'h80;
   // Range-select codes
   localparam logic [2:0] RANGE_BIP_3X  = 3'h7;
   localparam logic [2:0] RANGE_UNI_3X  = 3'h6;
   localparam logic [2:0] RANGE_UNI_1P5 = 3'h3;
   localparam logic [2:0] RANGE_RESET   = RANGE_BIP_3X;
   localparam logic       DIFF_RESET    = 1'b0;
   // Power states
   typedef enum logic [2:0] {
      APM_ACTIVE  = 3'b001,
      APM_PART_PD = 3'b010,
      APM_FULL_PD = 3'b100
   } apm_pwr_t;
   localparam apm_pwr_t PWR_RESET = APM_ACTIVE;
   localparam logic [2:0] CONV_RESET = MODE_EXT_CLK;
endpackage

// ---- src/apm_ser_if.sv ----
interface apm_ser_if;
   logic       byte_vld;
   logic [7:0] byte_val;
   modport rx  (output byte_vld, output byte_val);
   modport use_side (input byte_vld, input byte_val);
endinterface

// ---- src/apm_ser_rx.sv ----
module apm_ser_rx (
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic sclk_in,
   input  wire logic cs_n_in,
   input  wire logic din_in,
   apm_ser_if.rx     rx
);
   ////////////////////////////////////////////////////////////////
   logic [1:0] sclk_s_r;
   logic [1:0] cs_s_r;
   logic [1:0] din_s_r;
   logic       sclk_d_r;
   logic       started_r;
   logic [2:0] cnt_r;
   logic [7:0] sh_r;
   logic       vld_r;
   logic [7:0] val_r;
   wire        rise = sclk_s_r[1] & ~sclk_d_r;
   wire        sel  = ~cs_s_r[1];
   // Leading zeros are idle until the start bit
   wire        take = sel & rise & (started_r | din_s_r[1]);
   wire        last = take & (cnt_r == 3'h7);
   wire [7:0]  sh_nxt = {sh_r[6:0], din_s_r[1]};
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_s_r  <= 2'h0;
         cs_s_r    <= 2'h3;
         din_s_r   <= 2'h0;
         sclk_d_r  <= 1'b0;
      end else begin
         sclk_s_r  <= {sclk_s_r[0], sclk_in};
         cs_s_r    <= {cs_s_r[0], cs_n_in};
         din_s_r   <= {din_s_r[0], din_in};
         sclk_d_r  <= sclk_s_r[1];
      end
   end
   // Frame aborted by chip select rising: partial byte discarded
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         started_r <= 1'b0;
         cnt_r     <= 3'h0;
         sh_r      <= 8'h00;
      end else if (!sel || last) begin
         started_r <= 1'b0;
         cnt_r     <= 3'h0;
      end else if (take) begin
         started_r <= 1'b1;
         cnt_r     <= cnt_r + 3'h1;
         sh_r      <= sh_nxt;
      end
   end
   always_ff @(posedge core_clk_in or posedge rst_in) begin
      if (rst_in) begin
         vld_r <= 1'b0;
         val_r <= 8'h00;
      end else begin
         vld_r <= last;
         if (last) val_r <= sh_nxt;
      end
   end
   assign rx.byte_vld = vld_r;
   assign rx.byte_val = val_r;
endmodule

// ---- testbench/apm_host.sv ----
module apm_host (
   output logic sclk_out,
   output logic cs_n_out,
   output logic din_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      din_out  = 1'b1;
   end
   // Never sends a conversion start, so no settling wait is broken
   // Serial clock idles low between frames
   task automatic send(input logic [15:0] w, input int n);
      cs_n_out = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         din_out = w[i];
         #100 sclk_out = 1'b1;
         #100 sclk_out = 1'b0;
      end
      // Released line must not keep the last bit
      din_out = ~din_out;
      #100 cs_n_out = 1'b1;
      #400;
   endtask
endmodule

// ---- testbench/apm_top_sva.sv ----
module apm_top_sva #(
   parameter int NUM_CH = 8
) (
   input wire logic                      core_clk_in,
   input wire logic                      rst_in,
   input wire logic                      cs_n_in,
   input wire logic                      cfg_we_in,
   input wire logic [$clog2(NUM_CH)-1:0] cfg_ch_in,
   input wire logic [2:0]                cfg_range_in,
   input wire logic [2:0]                conv_mode_out,
   input wire logic                      part_pd_out,
   input wire logic                      full_pd_out,
   input wire logic                      ref_bias_on_out,
   input wire logic                      analog_on_out,
   input wire logic [NUM_CH-1:0]         ch_diff_out,
   input wire logic [NUM_CH*3-1:0]       ch_range_out,
   input wire logic [NUM_CH-1:0]         ch_unipolar_out,
   input wire logic [NUM_CH*2-1:0]       ch_span_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   chk_pd_onehot: assert property (
      !(part_pd_out && full_pd_out)) else $error("both power-down states");
   chk_ref_bias: assert property (
      ref_bias_on_out == !full_pd_out) else $error("reference power wrong");
   chk_analog_off: assert property (
      analog_on_out == !(part_pd_out || full_pd_out)) else $error("analog power wrong");
   chk_cs_no_exit: assert property (
      cs_n_in [*8] |=> $stable(part_pd_out) && $stable(full_pd_out) && $stable(conv_mode_out))
      else $error("state changed with chip select idle");
   chk_por_state: assert property (
      $fell(rst_in) |-> conv_mode_out == 3'h0 && analog_on_out && ref_bias_on_out)
      else $error("power-on state wrong");
   chk_por_range: assert property (
      $fell(rst_in) |-> ch_range_out == {NUM_CH{3'h7}} && ch_diff_out == '0)
      else $error("power-on ranges wrong");
   chk_conv_code: assert property (
      conv_mode_out <= 3'h2) else $error("illegal conversion mode");
   chk_span_3x: assert property (
      (ch_range_out[2:0] == 3'h6 && !ch_diff_out[0]) [*2]
      |-> ch_unipolar_out[0] && ch_span_out[1:0] == 2'h2)
      else $error("span of code 6 wrong");
   chk_span_1p5: assert property (
      (ch_range_out[5:3] == 3'h3 && !ch_diff_out[1]) [*2]
      |-> ch_unipolar_out[1] && ch_span_out[3:2] == 2'h1)
      else $error("span of code 3 wrong");
   chk_cfg_take: assert property (
      cfg_we_in && cfg_ch_in == '0 |=> ch_range_out[2:0] == $past(cfg_range_in))
      else $error("channel write lost");
endmodule
bind apm_top apm_top_sva #(.NUM_CH(NUM_CH)) apm_top_sva_i (.*);

// ---- testbench/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct { logic [15:0] w; int n; logic [2:0] c; logic p; logic f; } apm_row_t;
   logic        core_clk_in, rst_in, sclk, cs_n, din, we, diff;
   logic [2:0]  ch, rng, conv;
   logic        part, full, refb, ana;
   logic [7:0]  cdiff, uni;
   logic [23:0] crng;
   logic [15:0] span;
   int          bad_count = 0, n_compared = 0, cyc = 0;
   apm_row_t rows [12] = '{
      '{16'h00E8, 16, 3'h0, 1, 0}, '{16'h00B8, 8, 3'h0, 1, 0}, '{16'h000F, 4, 3'h0, 1, 0},
      '{16'h00F8, 8, 3'h0, 0, 1}, '{16'h00D8, 8, 3'h0, 0, 1}, '{16'h00E8, 8, 3'h0, 1, 0},
      '{16'h0098, 8, 3'h1, 0, 0}, '{16'h00A8, 8, 3'h2, 0, 0}, '{16'h00A9, 8, 3'h2, 0, 0},
      '{16'h00C8, 8, 3'h0, 0, 0}, '{16'h00F8, 8, 3'h0, 0, 1}, '{16'h0088, 8, 3'h0, 0, 0}};
   apm_host apm_host_i (.sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
   apm_top apm_top_i (.core_clk_in(core_clk_in), .rst_in(rst_in), .sclk_in(sclk),
      .cs_n_in(cs_n), .din_in(din), .cfg_we_in(we), .cfg_ch_in(ch), .cfg_diff_in(diff),
      .cfg_range_in(rng), .conv_mode_out(conv), .part_pd_out(part), .full_pd_out(full),
      .ref_bias_on_out(refb), .analog_on_out(ana), .ch_diff_out(cdiff),
      .ch_range_out(crng), .ch_unipolar_out(uni), .ch_span_out(span));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic st(input logic [2:0] c, input logic p, input logic f);
      chk("mode", {c, p, f, !f, !(p || f)}, {conv, part, full, refb, ana});
   endtask
   task automatic wr(input logic [2:0] c, input logic d, input logic [2:0] r);
      @(negedge core_clk_in);
      {ch, diff, rng, we} = {c, d, r, 1'b1};
      @(negedge core_clk_in);
      we = 1'b0;
      @(negedge core_clk_in);
   endtask
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      core_clk_in = 1'b0;
      forever #12.5 core_clk_in = ~core_clk_in;
   end
   // Whole run is near 1200 cycles
   always @(posedge core_clk_in) begin
      cyc++;
      if (cyc == 4000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      {rst_in, we, diff, ch, rng} = {1'b1, 8'h00};
      repeat (10) @(negedge core_clk_in);
      rst_in = 1'b0;
      st(3'h0, 1'b0, 1'b0);
      chk("cfg", {8'h00, 24'hFFFFFF}, {cdiff, crng});
      repeat (2) @(negedge core_clk_in);
      foreach (rows[i]) begin
         apm_host_i.send(rows[i].w, rows[i].n);
         @(negedge core_clk_in);
         st(rows[i].c, rows[i].p, rows[i].f);
      end
      wr(3'h0, 1'b0, 3'h6);
      wr(3'h1, 1'b0, 3'h3);
      chk("ch0", {4'h0, 7'h36}, {cdiff[0], uni[0], span[1:0], crng[2:0]});
      chk("ch1", {4'h0, 7'h2B}, {cdiff[1], uni[1], span[3:2], crng[5:3]});
      apm_host_i.send(16'h00C8, 8);
      chk("cfg", {8'h00, 24'hFFFFFF}, {cdiff, crng});
      wr(3'h2, 1'b1, 3'h6);
      chk("ch2", {4'h0, 7'h46}, {cdiff[2], uni[2], span[5:4], crng[8:6]});
      rst_in = 1'b1;
      repeat (2) @(negedge core_clk_in);
      rst_in = 1'b0;
      st(3'h0, 1'b0, 1'b0);
      chk("cfg", {8'h00, 24'hFFFFFF}, {cdiff, crng});
      finish_test();
   end
endmodule
